//--- rtl/cfri_pkg.sv
// Purpose: shared constants for the card feed release interlock
// Assumes: 250 MHz system clock, times given in milliseconds
// Notes:   long counts are overridable parameters of the top module
package cfri_pkg;
   localparam int unsigned CLK_HZ          = 250_000_000;
   localparam int unsigned READ_GAIN_MS    = 21;  // read release gain
   localparam int unsigned PUNCH_GAIN_MS   = 37;  // punch release gain
   localparam int unsigned READ_CYC        = READ_GAIN_MS * (CLK_HZ / 1000);
   localparam int unsigned PUNCH_CYC       = PUNCH_GAIN_MS * (CLK_HZ / 1000);
   localparam int unsigned CNT_W           = 24;
   localparam int unsigned ADDR_W          = 14;
   localparam int unsigned LEN_W           = 4;
   localparam logic [3:0]  SYNC_INIT       = 4'h0;

   // feed sequencer states, one-hot
   typedef enum logic [2:0]
   {
      CF_IDLE  = 3'b001,
      CF_WAIT  = 3'b010,
      CF_STOP  = 3'b100
   } cfri_state_e;

   // storage cycles taken by an instruction of given length
   function automatic logic [LEN_W:0] cfri_cycles(input logic [LEN_W-1:0] len);
      cfri_cycles = {1'b0, len} + {{LEN_W{1'b0}}, 1'b1};
   endfunction
endpackage

//--- rtl/cfri_window.sv
// Purpose: one release window: feed start, deadline timer, overrun stop
// Assumes: issue and honour strobes are one-cycle pulses on i_clk_sys
// Notes:   i_station comes from the synchronised station-ready pin
module cfri_window
   import cfri_pkg::*;
#(
   parameter int unsigned WIN_CYC = READ_CYC
)
(
   input  wire logic              i_clk_sys,
   input  wire logic              i_srst,
   input  wire logic              i_ce,
   input  wire logic              i_release,   // early feed issued
   input  wire logic              i_honour,    // matching read/punch
   input  wire logic              i_station,   // station ready, synced
   output logic                   o_feed,      // feed start pulse
   output logic                   o_pending,   // interlock released
   output logic                   o_overrun,   // overrun stop pulse
   output logic                   o_late       // window time exceeded
);
   cfri_state_e            state_r;
   logic [CNT_W-1:0]       cnt_r;

   // window sequencer
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
         state_r <= CF_IDLE;
      else if (i_ce)
      begin
         case (state_r)
            CF_IDLE:
               if (i_release)
                  state_r <= CF_WAIT;
            CF_WAIT:
               if (i_honour)
                  state_r <= CF_IDLE;
               else if (i_station)
                  state_r <= CF_STOP;
            CF_STOP:
               state_r <= CF_IDLE;
            default:
               state_r <= CF_IDLE;
         endcase
      end
   end

   // elapsed time since release
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
         cnt_r <= '0;
      else if (i_ce)
      begin
         if (state_r != CF_WAIT)
            cnt_r <= '0;
         else if (cnt_r != CNT_W'(WIN_CYC))
            cnt_r <= cnt_r + CNT_W'(1);
      end
   end

   // registered outputs
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         o_feed    <= 1'b0;
         o_pending <= 1'b0;
         o_overrun <= 1'b0;
         o_late    <= 1'b0;
      end
      else if (i_ce)
      begin
         o_feed    <= (state_r == CF_IDLE) && i_release;
         o_pending <= (state_r == CF_WAIT) && !i_honour && !i_station;
         o_overrun <= (state_r == CF_WAIT) && !i_honour && i_station;
         o_late    <= (state_r == CF_WAIT) && (cnt_r == CNT_W'(WIN_CYC));
      end
   end
endmodule // cfri_window

//--- rtl/cfri_top.sv
// Purpose: read and punch start-time interlock release control
// Assumes: instruction decode strobes are same-clock one-cycle pulses
// Notes:   station-ready pins come from the feed mechanism, async
//
// Operation
// - early read feed releases read interlock, about 21 ms more processing
// - early read feed also starts the read feed, next card advances
// - late read: card to reject pocket, machine stops, reader light on
// - after read overrun stop, address register points past late instr
// - early punch feed releases punch interlock, 37 ms, starts feed
// - late punch: card passes unpunched, stop, prior card unchecked
// - after punch overrun stop, address register points past late instr
// - early punch feed with feed-read modifier starts feed-read brushes
// - word marks kept, length plus one cycles, then next sequential instr
module cfri_top
   import cfri_pkg::*;
#(
   parameter int unsigned READ_WIN  = READ_CYC,
   parameter int unsigned PUNCH_WIN = PUNCH_CYC
)
(
   input  wire logic              i_clk_sys,
   input  wire logic              i_srst,
   input  wire logic              i_ce,
   input  wire logic              i_early_read_feed_instr,
   input  wire logic              i_early_punch_feed_instr,
   input  wire logic              i_feed_read_mod,
   input  wire logic              i_read_card,
   input  wire logic              i_punch_card,
   input  wire logic [LEN_W-1:0]  i_instr_len,
   input  wire logic [ADDR_W-1:0] i_instr_addr,
   input  wire logic              i_read_row9_ready,
   input  wire logic              i_punch_row12_ready,
   output logic                   o_read_feed,
   output logic                   o_punch_feed,
   output logic                   o_feed_read_brush,
   output logic                   o_read_released,
   output logic                   o_punch_released,
   output logic                   o_reject_pocket,
   output logic                   o_machine_stop,
   output logic                   o_reader_light,
   output logic                   o_skip_check,
   output logic                   o_read_late,
   output logic                   o_punch_late,
   output logic                   o_wordmark_we,
   output logic                   o_instr_done,
   output logic [ADDR_W-1:0]      o_next_sequential_instruction
);
   logic [2:0]        rd_sync_r;
   logic [2:0]        pn_sync_r;
   logic              rd_stn_r;
   logic              pn_stn_r;
   logic              rd_pend;
   logic              pn_pend;
   logic              rd_over;
   logic              pn_over;
   logic              rd_feed;
   logic              pn_feed;
   logic              rd_late;
   logic              pn_late;
   logic              brush_arm_r;
   logic [LEN_W:0]    busy_r;
   logic [ADDR_W-1:0] cur_addr_r;
   logic [ADDR_W-1:0] nsi_r;

   // three-stage synchronisers, change taken when stages two and three agree
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         rd_sync_r <= SYNC_INIT[2:0];
         pn_sync_r <= SYNC_INIT[2:0];
         rd_stn_r  <= 1'b0;
         pn_stn_r  <= 1'b0;
      end
      else if (i_ce)
      begin
         rd_sync_r <= {rd_sync_r[1:0], i_read_row9_ready};
         pn_sync_r <= {pn_sync_r[1:0], i_punch_row12_ready};
         if (rd_sync_r[1] == rd_sync_r[2])
            rd_stn_r <= rd_sync_r[2];
         if (pn_sync_r[1] == pn_sync_r[2])
            pn_stn_r <= pn_sync_r[2];
      end
   end

   // read release window
   cfri_window #(.WIN_CYC(READ_WIN)) u_read
   (
      .i_clk_sys (i_clk_sys),
      .i_srst    (i_srst),
      .i_ce      (i_ce),
      .i_release (i_early_read_feed_instr),
      .i_honour  (i_read_card),
      .i_station (rd_stn_r),
      .o_feed    (rd_feed),
      .o_pending (rd_pend),
      .o_overrun (rd_over),
      .o_late    (rd_late)
   );

   // punch release window
   cfri_window #(.WIN_CYC(PUNCH_WIN)) u_punch
   (
      .i_clk_sys (i_clk_sys),
      .i_srst    (i_srst),
      .i_ce      (i_ce),
      .i_release (i_early_punch_feed_instr),
      .i_honour  (i_punch_card),
      .i_station (pn_stn_r),
      .o_feed    (pn_feed),
      .o_pending (pn_pend),
      .o_overrun (pn_over),
      .o_late    (pn_late)
   );

   // feed starts and interlock release flags
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         o_read_feed      <= 1'b0;
         o_punch_feed     <= 1'b0;
         o_read_released  <= 1'b0;
         o_punch_released <= 1'b0;
         o_read_late      <= 1'b0;
         o_punch_late     <= 1'b0;
      end
      else if (i_ce)
      begin
         o_read_feed      <= rd_feed;
         o_punch_feed     <= pn_feed;
         o_read_released  <= rd_pend;
         o_punch_released <= pn_pend;
         o_read_late      <= rd_late;
         o_punch_late     <= pn_late;
      end
   end

   // feed-read brushes armed by modifier on early punch feed
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         brush_arm_r       <= 1'b0;
         o_feed_read_brush <= 1'b0;
      end
      else if (i_ce)
      begin
         if (i_early_punch_feed_instr)
            brush_arm_r <= i_feed_read_mod;
         o_feed_read_brush <= pn_feed && brush_arm_r;
      end
   end

   // overrun stop: stop and light sticky until reset, reset wins; reject and skip check pulse
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         o_machine_stop  <= 1'b0;
         o_reader_light  <= 1'b0;
         o_reject_pocket <= 1'b0;
         o_skip_check    <= 1'b0;
      end
      else if (i_ce)
      begin
         o_reject_pocket <= rd_over;
         o_skip_check    <= pn_over;
         if (rd_over || pn_over)
            o_machine_stop <= 1'b1;
         if (rd_over)
            o_reader_light <= 1'b1;
      end
   end

   // instruction timing: length plus one storage cycles
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         busy_r        <= '0;
         cur_addr_r    <= '0;
         o_instr_done  <= 1'b0;
         o_wordmark_we <= 1'b0;
      end
      else if (i_ce)
      begin
         o_wordmark_we <= 1'b0;  // word marks never written
         o_instr_done  <= 1'b0;
         if (i_early_read_feed_instr || i_early_punch_feed_instr)
         begin
            busy_r     <= cfri_cycles(i_instr_len);
            cur_addr_r <= i_instr_addr;
         end
         else if (busy_r != '0)
         begin
            busy_r       <= busy_r - (LEN_W+1)'(1);
            o_instr_done <= (busy_r == (LEN_W+1)'(1));
         end
      end
   end

   // next sequential instruction address, also reloaded on the first overrun stop
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
         nsi_r <= '0;
      else if (i_ce)
      begin
         if (i_early_read_feed_instr || i_early_punch_feed_instr)
            nsi_r <= i_instr_addr + ADDR_W'(i_instr_len);
         else if ((rd_over || pn_over) && !o_machine_stop)
            nsi_r <= i_instr_addr + ADDR_W'(i_instr_len);
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
         o_next_sequential_instruction <= '0;
      else if (i_ce)
         o_next_sequential_instruction <= nsi_r;
   end

   // checks
   a_read_stop: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      i_ce && rd_over |=> o_reject_pocket && o_machine_stop && o_reader_light)
      else $error("read overrun did not stop");
   a_punch_stop: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      i_ce && pn_over |=> o_machine_stop && o_skip_check)
      else $error("punch overrun did not stop");
   a_read_feed: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      i_ce && rd_feed |=> o_read_feed)
      else $error("read feed missing");
   a_punch_feed: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      i_ce && pn_feed |=> o_punch_feed)
      else $error("punch feed missing");
   a_read_rel: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      i_ce && rd_pend |=> o_read_released)
      else $error("read release missing");
   a_wm_kept: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      !o_wordmark_we)
      else $error("word mark written");
   a_brush_mod: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      o_feed_read_brush |-> o_punch_feed)
      else $error("brush without punch feed");
   a_stop_sticky: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      o_machine_stop |=> o_machine_stop)
      else $error("stop dropped");
endmodule // cfri_top

//--- tb/cfri_feed_model.sv
// Purpose: card feed mechanism model, raises station-ready after a feed
// Assumes: feed starts are one-cycle pulses from the block
// Notes:   ready stands for HOLD cycles, then drops back to not ready
module cfri_feed_model
#(
   parameter int DLY  = 20,
   parameter int HOLD = 8
)
(
   input  wire logic i_clk_sys,
   input  wire logic i_srst,
   input  wire logic i_read_feed,
   input  wire logic i_punch_feed,
   output logic      o_row9_ready,
   output logic      o_row12_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   int rd_cnt_r;
   int pu_cnt_r;
   // card travel toward the read station after a read feed start
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst) rd_cnt_r <= 0;
      else if (i_read_feed) rd_cnt_r <= DLY + HOLD;
      else if (rd_cnt_r != 0) rd_cnt_r <= rd_cnt_r - 1;
   end
   // card travel toward the punch station after a punch feed start
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst) pu_cnt_r <= 0;
      else if (i_punch_feed) pu_cnt_r <= DLY + HOLD;
      else if (pu_cnt_r != 0) pu_cnt_r <= pu_cnt_r - 1;
   end
   // ready while the row passes the station
   assign o_row9_ready  = (rd_cnt_r != 0) && (rd_cnt_r <= HOLD);
   assign o_row12_ready = (pu_cnt_r != 0) && (pu_cnt_r <= HOLD);
endmodule // cfri_feed_model

//--- tb/tb_top.sv
// Purpose: self-checking bench for the feed release interlock
// Assumes: inputs driven at the falling edge, 250 MHz clock
// Notes:   windows shortened to 16 cycles so the late flags are reached
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cfri_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_srst = 1'b1;
   logic [3:0] strb = 4'h0;  // early read, early punch, read, punch
   logic i_feed_read_mod = 1'b0;
   logic [LEN_W-1:0]  i_instr_len = 4'h0;
   logic [ADDR_W-1:0] i_instr_addr = 14'h0000;
   logic row9, row12, rfeed, pfeed, brush, rrel, prel, rej, stp, lit;
   logic skp, wm, done, rlate, plate;
   logic ce = 1'b1;
   logic [ADDR_W-1:0] next_sequential_instruction;
   int n_errors = 0;
   int n_compared = 0;
   always #2 i_clk_sys = ~i_clk_sys;
   cfri_top #(.READ_WIN(16), .PUNCH_WIN(16)) dut (
      .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_ce(ce),
      .i_early_read_feed_instr(strb[0]), .i_early_punch_feed_instr(strb[1]),
      .i_feed_read_mod(i_feed_read_mod), .i_read_card(strb[2]),
      .i_punch_card(strb[3]), .i_instr_len(i_instr_len),
      .i_instr_addr(i_instr_addr), .i_read_row9_ready(row9),
      .i_punch_row12_ready(row12), .o_read_feed(rfeed),
      .o_punch_feed(pfeed), .o_feed_read_brush(brush),
      .o_read_released(rrel), .o_punch_released(prel),
      .o_reject_pocket(rej), .o_machine_stop(stp), .o_reader_light(lit),
      .o_skip_check(skp), .o_read_late(rlate), .o_punch_late(plate),
      .o_wordmark_we(wm), .o_instr_done(done),
      .o_next_sequential_instruction(next_sequential_instruction));
   cfri_feed_model mdl (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
      .i_read_feed(rfeed), .i_punch_feed(pfeed),
      .o_row9_ready(row9), .o_row12_ready(row12));
   // verdict and end of run
   task summarize();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // compare a seen value with the expected one
   task chk(input string nm, input logic [ADDR_W-1:0] exp, got);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // wait for an output pulse, bounded
   task wait_hi(input int sel);
      logic v;
      for (int k = 0; k < 200; k++)
      begin
         @(negedge i_clk_sys);
         v = (sel == 0) ? rfeed : (sel == 1) ? pfeed : (sel == 2) ? rej :
             (sel == 3) ? skp : done;
         if (v === 1'b1) return;
      end
      n_errors++;
      $display("BAD wait %0d expected 1 seen timeout", sel);
      summarize();
   endtask
   // one-cycle strobe on a request input
   task pulse(input int sel);
      @(negedge i_clk_sys);
      strb[sel] = 1'b1;
      @(negedge i_clk_sys);
      strb[sel] = 1'b0;
   endtask
   // reset held two cycles, then synchronisers settle
   task do_reset();
      i_srst = 1'b1;
      repeat (2) @(negedge i_clk_sys);
      i_srst = 1'b0;
      repeat (4) @(negedge i_clk_sys);
   endtask
   // clock enable low: an early read feed is not taken, nothing moves
   task sc_freeze();
      i_instr_len = 4'h1;
      i_instr_addr = 14'h0055;
      ce = 1'b0;
      pulse(0);
      repeat (6) @(negedge i_clk_sys);
      chk("rel_frozen", 14'h0000, {13'h0, rrel});
      chk("nsi_frozen", 14'h0000, next_sequential_instruction);
      ce = 1'b1;
   endtask
   // early read feed followed by a timely read card
   task sc_read_ok();
      i_instr_len = 4'h3;
      i_instr_addr = 14'h0100;
      pulse(0);
      wait_hi(0);
      wait_hi(4);
      chk("nsi", 14'h0103, next_sequential_instruction);
      chk("wordmark", 14'h0000, {13'h0, wm});
      repeat (2) @(negedge i_clk_sys);
      chk("read_released", 14'h0001, {13'h0, rrel});
      pulse(2);
      repeat (40) @(negedge i_clk_sys);
      chk("read_released", 14'h0000, {13'h0, rrel});
      chk("stop", 14'h0000, {13'h0, stp});
      chk("read_late", 14'h0000, {13'h0, rlate});
   endtask
   // early punch feed with the feed-read modifier, punch in time
   task sc_punch_ok();
      i_feed_read_mod = 1'b1;
      i_instr_len = 4'h5;
      i_instr_addr = 14'h0a10;
      pulse(1);
      wait_hi(1);
      chk("brush", 14'h0001, {13'h0, brush});
      wait_hi(4);
      chk("nsi", 14'h0a15, next_sequential_instruction);
      i_feed_read_mod = 1'b0;
      repeat (2) @(negedge i_clk_sys);
      chk("punch_released", 14'h0001, {13'h0, prel});
      pulse(3);
      repeat (40) @(negedge i_clk_sys);
      chk("stop", 14'h0000, {13'h0, stp});
      chk("punch_late", 14'h0000, {13'h0, plate});
   endtask
   // read card never comes: reject, stop, light, address past
   task sc_read_late();
      i_instr_len = 4'h7;
      i_instr_addr = 14'h0200;
      pulse(0);
      i_instr_addr = 14'h0240;
      i_instr_len = 4'h4;
      repeat (20) @(negedge i_clk_sys);
      chk("read_late", 14'h0001, {13'h0, rlate});
      wait_hi(2);
      @(negedge i_clk_sys);
      chk("stop", 14'h0001, {13'h0, stp});
      chk("light", 14'h0001, {13'h0, lit});
      chk("nsi", 14'h0244, next_sequential_instruction);
   endtask
   // punch card never comes: unchecked card, stop, address past
   task sc_punch_late();
      i_instr_len = 4'h2;
      i_instr_addr = 14'h3ffc;
      pulse(1);
      wait_hi(1);
      chk("brush", 14'h0000, {13'h0, brush});
      chk("nsi", 14'h3ffe, next_sequential_instruction);
      i_instr_addr = 14'h1230;
      i_instr_len = 4'h3;
      repeat (18) @(negedge i_clk_sys);
      chk("punch_late", 14'h0001, {13'h0, plate});
      wait_hi(3);
      @(negedge i_clk_sys);
      chk("stop", 14'h0001, {13'h0, stp});
      chk("nsi", 14'h1233, next_sequential_instruction);
   endtask
   initial
   begin
      do_reset();
      sc_freeze();
      sc_read_ok();
      sc_punch_ok();
      sc_read_late();
      do_reset();
      sc_punch_late();
      summarize();
   end
endmodule // tb_top
